/* File: hdl/pfs_pkg.sv */
// Shared constants and types for the protection fault supervisor.
package pfs_pkg;

  // Number of switched channels
  localparam int PFS_CHANNELS = 5;

  // System clock period in ns (10 MHz)
  localparam int PFS_MCLK_PERIOD_NS = 100;

  // Shutdown deglitch time for overtemperature, in ns (5.0 us)
  localparam int PFS_OTS_DGL_NS = 5000;
  // Supply under/over voltage deglitch time, in ns (3.5 us)
  localparam int PFS_SUPPLY_DGL_NS = 3500;
  // Charge pump failure deglitch time, in ns (4.0 us)
  localparam int PFS_PUMP_DGL_NS = 4000;
  // Auto-restart period in Fail mode, in ms (64 ms)
  localparam int PFS_RESTART_MS = 64;

  // Deglitch counts, rounded up to whole cycles
  localparam int PFS_OTS_DGL_CYCLES =
    (PFS_OTS_DGL_NS + PFS_MCLK_PERIOD_NS - 1) / PFS_MCLK_PERIOD_NS;
  localparam int PFS_SUPPLY_DGL_CYCLES =
    (PFS_SUPPLY_DGL_NS + PFS_MCLK_PERIOD_NS - 1) / PFS_MCLK_PERIOD_NS;
  localparam int PFS_PUMP_DGL_CYCLES =
    (PFS_PUMP_DGL_NS + PFS_MCLK_PERIOD_NS - 1) / PFS_MCLK_PERIOD_NS;
  // Restart count; above 4096, so the top exposes it as a parameter
  localparam int PFS_RESTART_CYCLES =
    (PFS_RESTART_MS * 1000000) / PFS_MCLK_PERIOD_NS;

  // Warning threshold select values
  localparam logic PFS_WARN_SEL_HIGH = 1'b0;
  localparam logic PFS_WARN_SEL_LOW = 1'b1;

  // Reset values
  localparam logic [4:0] PFS_CHAN_RESET = 5'h00;
  localparam logic PFS_BIT_RESET = 1'b0;

  // Commands arriving from the serial link
  typedef enum logic [2:0] {
    PFS_CMD_NONE,
    PFS_CMD_READ_QUICK,
    PFS_CMD_READ_CHAN,
    PFS_CMD_READ_DEV,
    PFS_CMD_WRITE_ON
  } pfs_cmd_kind_t;

  // One link command: channel mask selects channels for channel reads and ON writes
  typedef struct packed {
    logic valid;
    pfs_cmd_kind_t kind;
    logic [4:0] chan_mask;
    logic [4:0] on_value;
  } pfs_cmd_t;

  // Raw analog comparator levels
  typedef struct packed {
    logic [4:0] warn_hi;
    logic [4:0] warn_lo;
    logic [4:0] shut;
    logic uv;
    logic ov;
    logic pump_bad;
    logic pump_settled;
  } pfs_sense_t;

  // Latched status as software sees it
  typedef struct packed {
    logic [4:0] quick_chan;
    logic [4:0] chan_warn;
    logic [4:0] chan_shut;
    logic low_supply_flag;
    logic high_supply_flag;
    logic pump_fault_flag;
    logic device_fault_summary_flag;
  } pfs_status_t;

endpackage

/* File: hdl/pfs_deglitch.sv */
// Restarting deglitch filter for one sensed fault condition.
`timescale 1ns/10ps
`default_nettype none

module pfs_deglitch
  import pfs_pkg::*;
#(
  parameter int CYCLES = 50
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic raw,
  output logic filt
);

  // Counter wide enough for the full period
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count_reg; // Cycles the condition has held
  logic filt_reg; // Filtered level
  logic [W-1:0] count_next;
  logic filt_next;

  // Any drop of the condition restarts the count
  assign count_next = !raw ? '0 : (count_reg == LAST) ? count_reg : count_reg + 1'b1; // [RULE18]
  assign filt_next = raw && (count_reg == LAST); // [RULE18]
  assign filt = filt_reg;

  // Counter and output register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      filt_reg <= PFS_BIT_RESET;
    end else begin
      count_reg <= count_next;
      filt_reg <= filt_next;
    end
  end

endmodule // pfs_deglitch

`default_nettype wire

/* File: hdl/pfs_supervisor.sv */
// Fault supervisor for five high-side channels: deglitch, shutdown, flags, restart.
//
// How it works
// [RULE1] Warning flags set; output left untouched.
// [RULE2] Deglitched shutdown disables output, then flags.
// [RULE3] Select zero high warning, one low.
// [RULE4] Channel flags clear: condition gone, channel read.
// [RULE5] Normal mode: ON write restarts after shutdown.
// [RULE6] Fail mode: shutdown held until mode transition.
// [RULE7] Deglitched undervoltage switches all outputs off.
// [RULE8] Undervoltage sets summary and low-supply flags.
// [RULE9] Normal mode: undervoltage restart needs ON write.
// [RULE10] Low-supply flag clears: recovered, device read.
// [RULE11] Fail mode: undervoltage restart is automatic.
// [RULE12] Overvoltage flag set; clears on recovery, read.
// [RULE13] Unsettled pump holds off, remembers turn-on.
// [RULE14] Deglitched pump failure disables, then flags.
// [RULE15] Pump recovery resumes with inrush window start.
// [RULE16] Pump flag clears: pump valid, quick read.
// [RULE17] Fail-mode auto restart after 64 ms.
// [RULE18] Deglitch counters restart when condition drops.
`timescale 1ns/10ps
`default_nettype none

module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int RESTART_CYCLES = PFS_RESTART_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire pfs_cmd_t link_cmd,
  input wire pfs_sense_t sense_in,
  input wire logic warn_threshold_select,
  input wire logic fail_mode,
  input wire logic mode_transition,
  output logic [4:0] out_enable,
  output logic [4:0] inrush_overcurrent_window,
  output pfs_status_t status,
  output pfs_status_t link_status
);

  // Restart counter width follows the parameter
  localparam int RW = $clog2(RESTART_CYCLES + 1);
  localparam logic [RW-1:0] RESTART_LAST = RW'(RESTART_CYCLES - 1);

  // Command kind test, used for every decoded command
  function automatic logic pfs_is(input pfs_cmd_t c, input pfs_cmd_kind_t k);
    pfs_is = (c.kind == k);
  endfunction

  // Sticky flag update: set wins over clear
  function automatic logic [4:0] pfs_flag(input logic [4:0] f, input logic [4:0] s,
                                          input logic [4:0] c);
    pfs_flag = s | (f & ~c);
  endfunction

  // Latched flags; declared here because the link side synchronises them
  pfs_status_t status_reg; // Latched flags
  pfs_status_t status_next;

  // ---------------- Link clock domain ----------------
  pfs_cmd_t cmd_hold_reg; // Held command word, stable until the next one
  logic cmd_tog_reg; // Toggles once per command
  pfs_status_t lstat_s1_reg; // Status synchroniser, first stage
  pfs_status_t lstat_reg; // Status synchroniser, second stage

  // Capture a command and flag it by a toggle; word stays put for the crossing
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_hold_reg <= '0;
      cmd_tog_reg <= PFS_BIT_RESET;
    end else if (link_cmd.valid) begin
      cmd_hold_reg <= link_cmd;
      cmd_tog_reg <= ~cmd_tog_reg;
    end
  end

  // Status levels back into the link domain, each bit on its own
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lstat_s1_reg <= '0;
      lstat_reg <= '0;
    end else begin
      lstat_s1_reg <= status_reg;
      lstat_reg <= lstat_s1_reg;
    end
  end

  assign link_status = lstat_reg;

  // ---------------- System clock domain ----------------
  logic tog_s1_reg; // Toggle synchroniser, first stage
  logic tog_s2_reg; // Toggle synchroniser, second stage
  logic tog_s3_reg; // Last seen toggle, for edge detection
  pfs_sense_t sense_s1_reg; // Comparator synchroniser, first stage
  pfs_sense_t sense_s2_reg; // Comparator synchroniser, second stage

  // Crossing flops: first stages feed only the second stages
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tog_s1_reg <= PFS_BIT_RESET;
      tog_s2_reg <= PFS_BIT_RESET;
      tog_s3_reg <= PFS_BIT_RESET;
      sense_s1_reg <= '0;
      sense_s2_reg <= '0;
    end else begin
      tog_s1_reg <= cmd_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      sense_s1_reg <= sense_in;
      sense_s2_reg <= sense_s1_reg;
    end
  end

  // Command decode; the held word is quiet by the time the toggle lands
  wire cmd_fire = tog_s2_reg ^ tog_s3_reg;
  wire rd_quick = cmd_fire && pfs_is(cmd_hold_reg, PFS_CMD_READ_QUICK);
  wire rd_chan_any = cmd_fire && pfs_is(cmd_hold_reg, PFS_CMD_READ_CHAN);
  wire rd_dev = cmd_fire && pfs_is(cmd_hold_reg, PFS_CMD_READ_DEV);
  wire wr_on = cmd_fire && pfs_is(cmd_hold_reg, PFS_CMD_WRITE_ON);
  wire [4:0] rd_chan = rd_chan_any ? cmd_hold_reg.chan_mask : PFS_CHAN_RESET;
  wire [4:0] wr_set = wr_on ? (cmd_hold_reg.chan_mask & cmd_hold_reg.on_value) : PFS_CHAN_RESET;
  wire [4:0] wr_clr = wr_on ? (cmd_hold_reg.chan_mask & ~cmd_hold_reg.on_value) : PFS_CHAN_RESET;

  // Synchronised comparator levels
  wire [4:0] shut_raw = sense_s2_reg.shut;
  wire uv_raw = sense_s2_reg.uv;
  wire ov_raw = sense_s2_reg.ov;
  wire pump_settled = sense_s2_reg.pump_settled;
  // Pump failure only counts once the pump has settled at power-up
  wire pump_bad_raw = sense_s2_reg.pump_bad && pump_settled;

  // Warning threshold choice
  wire [4:0] warn_now = (warn_threshold_select == PFS_WARN_SEL_LOW) ?
                        sense_s2_reg.warn_lo : sense_s2_reg.warn_hi; // [RULE3]

  // Deglitched fault levels
  logic [4:0] ots_filt;
  logic uv_filt;
  logic ov_filt;
  logic pump_filt;

  // One shutdown filter per channel
  genvar g;
  generate
    for (g = 0; g < PFS_CHANNELS; g++) begin : g_ots
      pfs_deglitch #(.CYCLES(PFS_OTS_DGL_CYCLES)) u_ots (
        .mclk(mclk),
        .reset_n(reset_n),
        .raw(shut_raw[g]),
        .filt(ots_filt[g])
      );
    end
  endgenerate

  // Supply and pump filters
  pfs_deglitch #(.CYCLES(PFS_SUPPLY_DGL_CYCLES)) u_uv (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw(uv_raw),
    .filt(uv_filt)
  );

  pfs_deglitch #(.CYCLES(PFS_SUPPLY_DGL_CYCLES)) u_ov (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw(ov_raw),
    .filt(ov_filt)
  );

  pfs_deglitch #(.CYCLES(PFS_PUMP_DGL_CYCLES)) u_pump (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw(pump_bad_raw),
    .filt(pump_filt)
  );

  // Pump usable: settled and no deglitched failure
  wire pump_ok = pump_settled && !pump_filt; // [RULE13] [RULE14]

  // ---------------- Output control ----------------
  logic [4:0] on_cmd_reg; // Commanded state, kept through any fault
  logic [4:0] ots_off_reg; // Channel held off by thermal shutdown
  logic [4:0] uv_off_reg; // Channel held off by undervoltage
  logic [4:0] out_enable_reg; // Driven gate enable
  logic [4:0] inrush_reg; // One-cycle start of the inrush window
  logic [RW-1:0] restart_cnt_reg; // Fail-mode restart timer
  logic pump_filt_d_reg; // Pump fault one cycle late, orders disable before flag

  // Command memory; a turn-on during a pump fault waits here
  wire [4:0] on_cmd_next = (on_cmd_reg | wr_set) & ~wr_clr; // [RULE13] [RULE15]

  // Thermal release: ON write in Normal mode, mode change in Fail mode
  wire [4:0] ots_release = fail_mode ? (mode_transition ? ~shut_raw : PFS_CHAN_RESET) // [RULE6]
                                     : (wr_set & ~shut_raw); // [RULE5]
  wire [4:0] ots_off_next = ots_filt | (ots_off_reg & ~ots_release); // [RULE2]

  // Restart timer runs only in Fail mode once the supply is back
  wire restart_run = fail_mode && (|uv_off_reg) && !uv_raw;
  wire restart_due = restart_run && (restart_cnt_reg == RESTART_LAST); // [RULE17]
  wire [RW-1:0] restart_cnt_next = !restart_run ? '0 :
                                   restart_due ? '0 : restart_cnt_reg + 1'b1; // [RULE17]

  // Undervoltage release: ON write in Normal mode, timer in Fail mode
  wire [4:0] uv_release = uv_raw ? PFS_CHAN_RESET :
                          fail_mode ? {PFS_CHANNELS{restart_due}} : wr_set; // [RULE9] [RULE11]
  wire [4:0] uv_off_next = {PFS_CHANNELS{uv_filt}} | (uv_off_reg & ~uv_release); // [RULE7]

  // Gate enable; warnings deliberately play no part here
  wire [4:0] out_enable_next = on_cmd_next & ~ots_off_next & ~uv_off_next &
                               {PFS_CHANNELS{pump_ok}}; // [RULE1] [RULE13] [RULE14]
  // Every off-to-on start, including after pump recovery, opens the window
  wire [4:0] inrush_next = out_enable_next & ~out_enable_reg; // [RULE15]

  // Output state registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      on_cmd_reg <= PFS_CHAN_RESET;
      ots_off_reg <= PFS_CHAN_RESET;
      uv_off_reg <= PFS_CHAN_RESET;
      out_enable_reg <= PFS_CHAN_RESET;
      inrush_reg <= PFS_CHAN_RESET;
      restart_cnt_reg <= '0;
      pump_filt_d_reg <= PFS_BIT_RESET;
    end else begin
      on_cmd_reg <= on_cmd_next;
      ots_off_reg <= ots_off_next;
      uv_off_reg <= uv_off_next;
      out_enable_reg <= out_enable_next;
      inrush_reg <= inrush_next;
      restart_cnt_reg <= restart_cnt_next;
      pump_filt_d_reg <= pump_filt;
    end
  end

  assign out_enable = out_enable_reg;
  assign inrush_overcurrent_window = inrush_reg;

  // ---------------- Status flags ----------------
  // Shutdown flag trails the disable by a cycle: output is already off
  wire [4:0] shut_set = ots_off_reg & ots_filt; // [RULE2]
  // Channel flags clear on a read of that channel, once cooled
  wire [4:0] warn_clr = rd_chan & ~warn_now; // [RULE4]
  wire [4:0] shut_clr = rd_chan & ~shut_raw; // [RULE4]

  // Supply flags clear on a device read, the pump flag on a quick read
  wire low_next = uv_filt || (status_reg.low_supply_flag && !(rd_dev && !uv_raw)); // [RULE8] [RULE10]
  wire high_next = ov_filt || (status_reg.high_supply_flag && !(rd_dev && !ov_raw)); // [RULE12]
  // Pump flag set from the late copy, after outputs have dropped
  wire pump_next = pump_filt_d_reg ||
                   (status_reg.pump_fault_flag && !(rd_quick && !pump_bad_raw)); // [RULE14] [RULE16]

  // Assemble the next status word
  always_comb begin
    status_next = status_reg;
    status_next.chan_warn = pfs_flag(status_reg.chan_warn, warn_now, warn_clr); // [RULE1]
    status_next.chan_shut = pfs_flag(status_reg.chan_shut, shut_set, shut_clr); // [RULE2]
    status_next.quick_chan = status_next.chan_warn | status_next.chan_shut; // [RULE1] [RULE2]
    status_next.low_supply_flag = low_next;
    status_next.high_supply_flag = high_next;
    status_next.pump_fault_flag = pump_next;
    // Summary shows any device-level fault
    status_next.device_fault_summary_flag = low_next || high_next || pump_next; // [RULE8] [RULE12]
  end

  // Status register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;

endmodule // pfs_supervisor

`default_nettype wire

/* File: dv/pfs_supervisor_props.sv */
// Concurrent checks on the fault supervisor ports.
`timescale 1ns/10ps
`default_nettype none
module pfs_supervisor_props
  import pfs_pkg::*;
#(
  parameter int RESTART_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire pfs_cmd_t link_cmd,
  input wire pfs_sense_t sense_in,
  input wire logic warn_threshold_select,
  input wire logic fail_mode,
  input wire logic mode_transition,
  input wire logic [4:0] out_enable,
  input wire logic [4:0] inrush_overcurrent_window,
  input wire pfs_status_t status,
  input wire pfs_status_t link_status
);
  // All checks live in the system clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Inrush pulse only on an off-to-on edge
  inrush_edge_a: assert property (inrush_overcurrent_window == (out_enable & ~$past(out_enable)))
    else $error("inrush pulse not tied to enable edge");
  // Shutdown flag only once the output is already off
  shut_order_a: assert property (((status.chan_shut & ~$past(status.chan_shut)) & $past(out_enable)) == 5'h00)
    else $error("shutdown flag before output off");
  // Shutdown flag held while the hot level persists
  shut_hold_a: assert property (($past(status.chan_shut) & ~status.chan_shut & sense_in.shut) == 5'h00)
    else $error("shutdown flag cleared while hot");
  uv_off_a: assert property ($rose(status.low_supply_flag) |-> out_enable == 5'h00)
    else $error("low supply flagged with outputs on");
  low_summary_a: assert property (status.low_supply_flag |-> status.device_fault_summary_flag)
    else $error("low supply without summary");
  high_summary_a: assert property (status.high_supply_flag |-> status.device_fault_summary_flag)
    else $error("high supply without summary");
  low_clear_a: assert property ($fell(status.low_supply_flag) |-> !sense_in.uv)
    else $error("low supply flag cleared during undervoltage");
  high_clear_a: assert property ($fell(status.high_supply_flag) |-> !sense_in.ov)
    else $error("high supply flag cleared during overvoltage");
  pump_off_a: assert property ($rose(status.pump_fault_flag) |-> $past(out_enable) == 5'h00)
    else $error("pump flag before outputs off");
  pump_clear_a: assert property ($fell(status.pump_fault_flag) |-> !sense_in.pump_bad)
    else $error("pump flag cleared while pump bad");
  // Margin of four cycles covers the input synchroniser
  unsettled_off_a: assert property (!sense_in.pump_settled [*4] |=> out_enable == 5'h00)
    else $error("output on with unsettled pump");
  warn_keep_a: assert property ($rose(|status.chan_warn) |-> $stable(out_enable))
    else $error("warning changed outputs");
endmodule // pfs_supervisor_props
bind pfs_supervisor pfs_supervisor_props #(.RESTART_CYCLES(RESTART_CYCLES)) pfs_supervisor_props_i (
  .mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .link_cmd(link_cmd),
  .sense_in(sense_in), .warn_threshold_select(warn_threshold_select),
  .fail_mode(fail_mode), .mode_transition(mode_transition), .out_enable(out_enable),
  .inrush_overcurrent_window(inrush_overcurrent_window), .status(status),
  .link_status(link_status));
`default_nettype wire

/* File: dv/pfs_link_master.sv */
// Controller model issuing link commands on the link clock.
`timescale 1ns/10ps
`default_nettype none
module pfs_link_master
  import pfs_pkg::*;
(
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic req_tgl,
  input wire pfs_cmd_t req_word,
  output pfs_cmd_t link_cmd
);
  logic [2:0] tgl_sync_reg; // Request toggle crossing from bench
  // One-cycle valid per request; idle fields churn so stale data is never trusted
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_sync_reg <= 3'h0;
      link_cmd <= '0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], req_tgl};
      if (tgl_sync_reg[2] != tgl_sync_reg[1]) begin
        link_cmd <= req_word;
      end else begin
        link_cmd <= pfs_cmd_t'({1'b0, ~link_cmd[12:0]});
      end
    end
  end
endmodule // pfs_link_master
`default_nettype wire

/* File: dv/tb_pfs_supervisor.sv */
// Self-checking bench for the fault supervisor.
`timescale 1ns/10ps
`default_nettype none
module tb_pfs_supervisor;
  import pfs_pkg::*;
  localparam int RST_CYC = 20; // Shortened auto-restart count
  logic mclk, link_clk, reset_n, req_tgl, warn_threshold_select, fail_mode, mode_transition;
  pfs_cmd_t req_word, link_cmd;
  pfs_sense_t sense_in;
  logic [4:0] out_enable, inrush;
  pfs_status_t status, link_status;
  logic [4:0] oe_s, inrush_cnt; // Settled enable copy, inrush pulse total
  pfs_status_t st_s, ls_s; // Settled status copies
  int error_cnt, check_count, i;
  logic [31:0] seed, r;

  pfs_link_master pfs_link_master_i (.link_clk(link_clk), .reset_n(reset_n),
    .req_tgl(req_tgl), .req_word(req_word), .link_cmd(link_cmd));
  pfs_supervisor #(.RESTART_CYCLES(RST_CYC)) pfs_supervisor_i (.mclk(mclk), .reset_n(reset_n),
    .link_clk(link_clk), .link_cmd(link_cmd), .sense_in(sense_in),
    .warn_threshold_select(warn_threshold_select), .fail_mode(fail_mode),
    .mode_transition(mode_transition), .out_enable(out_enable),
    .inrush_overcurrent_window(inrush), .status(status), .link_status(link_status));

  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // Link clock unrelated in phase
  initial begin
    link_clk = 0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // Outputs copied at the falling edge, where they have settled
  always @(negedge mclk) begin
    oe_s <= out_enable;
    st_s <= status;
    ls_s <= link_status;
    if (!reset_n) inrush_cnt <= 5'h00;
    else inrush_cnt <= inrush_cnt + 5'($countones(inrush));
  end

  function automatic logic [4:0] exp_warn(input logic sel, input logic [4:0] hi, input logic [4:0] lo);
    return (sel == PFS_WARN_SEL_LOW) ? lo : hi;
  endfunction
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Quick bits show warnings and shutdowns; summary any device fault
  function automatic pfs_status_t exp_stat(input logic [4:0] warn, input logic [4:0] shut,
                                           input logic low, input logic high, input logic pump);
    pfs_status_t s;
    s.quick_chan = warn | shut;
    s.chan_warn = warn;
    s.chan_shut = shut;
    s.low_supply_flag = low;
    s.high_supply_flag = high;
    s.pump_fault_flag = pump;
    s.device_fault_summary_flag = low | high | pump;
    return s;
  endfunction
  task automatic chk_stat(input pfs_status_t got, input pfs_status_t exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Spacing of 20 system cycles keeps commands well apart on the link
  task automatic send(input pfs_cmd_kind_t k, input logic [4:0] m, input logic [4:0] v);
    req_word <= '{valid: 1'b1, kind: k, chan_mask: m, on_value: v};
    req_tgl <= ~req_tgl;
    cyc(20);
  endtask
  task automatic wait_out(input logic [4:0] exp);
    int n;
    for (n = 0; n < 200 && oe_s !== exp; n++) cyc(1);
    chk(oe_s, exp);
    if (n == 200) report_and_stop();
  endtask

  initial begin
    seed = 32'h2921;
    reset_n = 0;
    req_tgl = 0;
    req_word = '0;
    sense_in = '0;
    sense_in.pump_settled = 1;
    warn_threshold_select = 0;
    fail_mode = 0;
    mode_transition = 0;
    error_cnt = 0;
    check_count = 0;
    cyc(3);
    reset_n <= 1;
    cyc(3);
    send(PFS_CMD_WRITE_ON, 5'h1F, 5'h1F);
    wait_out(5'h1F);
    // Random warning levels, first one a fixed corner
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      if (i == 0) r = 32'h0000_0004;
      warn_threshold_select <= r[10];
      sense_in.warn_hi <= r[4:0];
      sense_in.warn_lo <= r[9:5];
      send(PFS_CMD_READ_CHAN, 5'h1F, 5'h00);
      chk(st_s.chan_warn, exp_warn(r[10], r[4:0], r[9:5]));
      chk(oe_s, 5'h1F);
      sense_in.warn_hi <= 5'h00;
      sense_in.warn_lo <= 5'h00;
      cyc(4);
      send(PFS_CMD_READ_CHAN, 5'h1F, 5'h00);
      chk(st_s.chan_warn, 5'h00);
    end
    $display("test warning done");
    // A broken hot spell, then a long one
    sense_in.shut <= 5'h02;
    cyc(45);
    sense_in.shut <= 5'h00;
    cyc(5);
    sense_in.shut <= 5'h02;
    cyc(45);
    chk(oe_s, 5'h1F);
    cyc(15);
    chk(oe_s, 5'h1D);
    chk(st_s.chan_shut, 5'h02);
    // Whole word, as latched and as seen from the link side
    chk_stat(st_s, exp_stat(5'h00, 5'h02, 1'b0, 1'b0, 1'b0));
    chk_stat(ls_s, exp_stat(5'h00, 5'h02, 1'b0, 1'b0, 1'b0));
    send(PFS_CMD_WRITE_ON, 5'h02, 5'h02);
    chk(oe_s, 5'h1D);
    sense_in.shut <= 5'h00;
    cyc(4);
    send(PFS_CMD_READ_CHAN, 5'h02, 5'h00);
    chk(st_s.chan_shut, 5'h00);
    send(PFS_CMD_WRITE_ON, 5'h02, 5'h02);
    wait_out(5'h1F);
    $display("test shutdown done");
    sense_in.uv <= 1'b1;
    cyc(30);
    chk(oe_s, 5'h1F);
    cyc(15);
    chk(oe_s, 5'h00);
    chk({3'h0, st_s.low_supply_flag, st_s.device_fault_summary_flag}, 5'h03);
    sense_in.uv <= 1'b0;
    sense_in.ov <= 1'b1;
    cyc(45);
    chk(oe_s, 5'h00);
    chk({4'h0, st_s.high_supply_flag}, 5'h01);
    sense_in.ov <= 1'b0;
    cyc(4);
    send(PFS_CMD_READ_DEV, 5'h00, 5'h00);
    chk({3'h0, st_s.low_supply_flag, st_s.high_supply_flag}, 5'h00);
    send(PFS_CMD_WRITE_ON, 5'h1F, 5'h1F);
    wait_out(5'h1F);
    $display("test supply done");
    sense_in.pump_bad <= 1'b1;
    cyc(50);
    chk(oe_s, 5'h00);
    send(PFS_CMD_READ_QUICK, 5'h00, 5'h00);
    chk({4'h0, st_s.pump_fault_flag}, 5'h01);
    sense_in.pump_bad <= 1'b0;
    wait_out(5'h1F);
    cyc(4);
    send(PFS_CMD_READ_QUICK, 5'h00, 5'h00);
    chk({4'h0, st_s.pump_fault_flag}, 5'h00);
    sense_in.pump_settled <= 1'b0;
    send(PFS_CMD_WRITE_ON, 5'h01, 5'h00);
    chk(oe_s, 5'h00);
    sense_in.pump_settled <= 1'b1;
    wait_out(5'h1E);
    $display("test pump done");
    fail_mode <= 1'b1;
    sense_in.uv <= 1'b1;
    cyc(45);
    sense_in.uv <= 1'b0;
    // Restart due RST_CYC cycles after the synchronised supply recovers
    cyc(21);
    chk(oe_s, 5'h00);
    cyc(2);
    chk(oe_s, 5'h1E);
    sense_in.shut <= 5'h04;
    cyc(60);
    sense_in.shut <= 5'h00;
    cyc(40);
    chk(oe_s, 5'h1A);
    mode_transition <= 1'b1;
    cyc(1);
    mode_transition <= 1'b0;
    wait_out(5'h1E);
    // One window per off-to-on start across all scenarios
    chk(inrush_cnt, 5'h19);
    $display("test fail mode done");
    report_and_stop();
  end
endmodule // tb_pfs_supervisor
`default_nettype wire
